/* design/tsom_pkg.sv */
package tsom_pkg;

  // ****************************************************************
  // Auxiliary pin source codes
  // ****************************************************************
  localparam logic [3:0] AUX_TRISTATE = 4'h0;
  localparam logic [3:0] AUX_DAC_REG = 4'h1;
  localparam logic [3:0] AUX_DAC_CORR = 4'h2;
  localparam logic [3:0] AUX_DAC_MINLVL = 4'h4;
  localparam logic [3:0] AUX_ADC_I = 4'h5;
  localparam logic [3:0] AUX_ADC_Q = 4'h6;
  localparam logic [3:0] AUX_HIGH = 4'hA;
  localparam logic [3:0] AUX_LOW = 4'hB;
  localparam logic [3:0] AUX_TX_ACT = 4'hC;
  localparam logic [3:0] AUX_RX_ACT = 4'hD;
  localparam logic [3:0] AUX_SUBC = 4'hE;
  localparam logic [3:0] AUX_TEST_BIT = 4'hF;

  // ****************************************************************
  // Selector field layouts and reset values
  // ****************************************************************
  localparam int AUX_ONE_LSB = 4;
  localparam int AUX_TWO_LSB = 0;
  localparam logic [7:0] ANALOG_SEL_RST = 8'h00;
  localparam logic [4:0] GROUP_RX = 5'h07;
  localparam logic [2:0] PICK_RX_DATA = 3'h6;

  // ****************************************************************
  // Data rates and pattern modes
  // ****************************************************************
  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] PRBS_OFF = 2'h0;
  localparam logic [1:0] PRBS_9 = 2'h1;
  localparam logic [1:0] PRBS_15 = 2'h2;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam int BUS_WIDTH = 6;

  // Frame phase reported by the transceiver
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_START = 3'b001,
    PH_DATA = 3'b011,
    PH_PARITY = 3'b010,
    PH_CRC = 3'b110
  } tsom_phase_t;

endpackage

/* design/tsom_prbs_gen.sv */
`timescale 1ns/1ps
module tsom_prbs_gen
  import tsom_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Control
  input wire logic [1:0] mode_i,
  input wire logic load_i,
  input wire logic step_i,
  // Pattern bit
  output logic bit_o
);

  typedef struct packed {
    logic [14:0] lfsr;
  } tsom_prbs_st_t;

  tsom_prbs_st_t st_reg;
  tsom_prbs_st_t st_next;

  // ****************************************************************
  // Shift register, taps x^9+x^5+1 or x^15+x^14+1
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    if (load_i) begin
      st_next.lfsr = PRBS_SEED;
    end else if (step_i) begin
      if (mode_i == PRBS_9) begin
        st_next.lfsr = {6'h00, st_reg.lfsr[7:0],
                        st_reg.lfsr[8] ^ st_reg.lfsr[4]};
      end else begin
        st_next.lfsr = {st_reg.lfsr[13:0],
                        st_reg.lfsr[14] ^ st_reg.lfsr[13]};
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_reg <= '{lfsr: PRBS_SEED};
    end else begin
      st_reg <= st_next;
    end
  end

  // Output bit from the last stage
  assign bit_o = (mode_i == PRBS_9) ? st_reg.lfsr[8] : st_reg.lfsr[14];

endmodule

/* design/tsom_test_mux.sv */
`timescale 1ns/1ps
module tsom_test_mux
  import tsom_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Selectors
  input wire logic [7:0] analog_test_selector_i,
  input wire logic [4:0] test_bus_group_select_i,
  input wire logic [2:0] bus_bit_picker_i,
  input wire logic [1:0] prbs_mode_i,
  // Transceiver state
  input wire logic [1:0] data_rate_i,
  input wire logic [2:0] rx_phase_i,
  input wire logic [2:0] tx_phase_i,
  input wire logic transmit_cmd_i,
  input wire logic tx_bit_strobe_i,
  input wire logic tx_frame_end_i,
  input wire logic framing_insert_i,
  // Receiver test signals
  input wire logic rx_data_i,
  input wire logic rx_coll_i,
  input wire logic rx_valid_i,
  input wire logic rx_stop_i,
  input wire logic receiver_reset_line_i,
  input wire logic subcarrier_det_i,
  // Converter sample streams, one bit each
  input wire logic adc_i_i,
  input wire logic adc_q_i,
  input wire logic dac_reg_one_i,
  input wire logic dac_reg_two_i,
  input wire logic dac_corr_i,
  input wire logic dac_minlvl_i,
  // Auxiliary pins
  output logic analog_out_one_o,
  output logic analog_out_one_oe_n_o,
  output logic analog_out_two_o,
  output logic analog_out_two_oe_n_o,
  // Digital test bus pins D1..D6
  output logic [5:0] test_bus_o,
  // Pattern transmit, picked test bit and activity flags
  output logic prbs_active_o,
  output logic prbs_data_o,
  output logic picked_test_bit_o,
  output logic transmit_activity_o,
  output logic receive_activity_o
);

  typedef struct packed {
    logic analog_out_one;
    logic analog_out_one_oe_n;
    logic analog_out_two;
    logic analog_out_two_oe_n;
    logic [5:0] bus;
    logic pick;
    logic tx_act;
    logic rx_act;
    logic prbs_on;
    logic prbs_bit;
  } tsom_st_t;

  tsom_st_t st_reg;
  tsom_st_t st_next;
  logic prbs_bit;
  logic prbs_load;
  logic prbs_step;
  logic [5:0] bus_now;

  // ****************************************************************
  // Source decode, shared by both auxiliary pins
  // ****************************************************************
  function automatic logic aux_value(input logic [3:0] code,
                                     input logic dac_reg,
                                     input logic tx_act,
                                     input logic rx_act,
                                     input logic pick);
    logic v;
    v = 1'b0;
    case (code)
      AUX_DAC_REG: v = dac_reg;
      AUX_DAC_CORR: v = dac_corr_i;
      AUX_DAC_MINLVL: v = dac_minlvl_i;
      AUX_ADC_I: v = adc_i_i;
      AUX_ADC_Q: v = adc_q_i;
      AUX_HIGH: v = 1'b1;
      AUX_LOW: v = 1'b0;
      AUX_TX_ACT: v = tx_act;
      AUX_RX_ACT: v = rx_act;
      AUX_SUBC: v = subcarrier_det_i;
      AUX_TEST_BIT: v = pick;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // Picker value n selects pin Dn; 0 and 7 read low, never out of range
  function automatic logic pick_line(input logic [5:0] lines,
                                     input logic [2:0] idx);
    logic v;
    v = 1'b0;
    if (idx != 3'h0 && idx != 3'h7) begin
      v = lines[idx - 3'h1];
    end
    return v;
  endfunction

  // Tristate code releases the pin, reserved codes drive low
  function automatic logic aux_oe_n(input logic [3:0] code);
    return (code == AUX_TRISTATE);
  endfunction

  // ****************************************************************
  // Pattern generator
  // ****************************************************************
  // Selecting a mode only arms it; the transmit command starts it
  assign prbs_load = transmit_cmd_i & (prbs_mode_i != PRBS_OFF);
  // Framing bits are inserted by the transmitter; hold the pattern then
  assign prbs_step = st_reg.prbs_on & tx_bit_strobe_i
                     & ~framing_insert_i;

  tsom_prbs_gen u_prbs (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .mode_i(prbs_mode_i),
    .load_i(prbs_load),
    .step_i(prbs_step),
    .bit_o(prbs_bit)
  );

  // Test bus contents for the receiver group
  always_comb begin
    bus_now = 6'h00;
    if (test_bus_group_select_i == GROUP_RX) begin
      bus_now = {rx_data_i, rx_coll_i, rx_valid_i, rx_stop_i,
                 receiver_reset_line_i, 1'b0};
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.bus = bus_now;
    st_next.pick = pick_line(bus_now, bus_bit_picker_i);
    if (data_rate_i == RATE_106) begin
      st_next.rx_act = (rx_phase_i == PH_DATA) | (rx_phase_i == PH_PARITY)
                       | (rx_phase_i == PH_CRC);
      st_next.tx_act = (tx_phase_i != PH_IDLE);
    end else begin
      st_next.rx_act = (rx_phase_i == PH_DATA)
                       | (rx_phase_i == PH_CRC);
      st_next.tx_act = (tx_phase_i == PH_DATA)
                       | (tx_phase_i == PH_CRC);
    end
    if (prbs_load) begin
      st_next.prbs_on = 1'b1;
    end else if (tx_frame_end_i || prbs_mode_i == PRBS_OFF) begin
      st_next.prbs_on = 1'b0;
    end
    st_next.prbs_bit = st_reg.prbs_on & prbs_bit;
    st_next.analog_out_one = aux_value(analog_test_selector_i[AUX_ONE_LSB +: 4],
                             dac_reg_one_i, st_reg.tx_act, st_reg.rx_act,
                             st_reg.pick);
    st_next.analog_out_one_oe_n = aux_oe_n(analog_test_selector_i[AUX_ONE_LSB +: 4]);
    st_next.analog_out_two = aux_value(analog_test_selector_i[AUX_TWO_LSB +: 4],
                             dac_reg_two_i, st_reg.tx_act, st_reg.rx_act,
                             st_reg.pick);
    st_next.analog_out_two_oe_n = aux_oe_n(analog_test_selector_i[AUX_TWO_LSB +: 4]);
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_reg <= '{analog_out_one: 1'b0, analog_out_one_oe_n: 1'b1, analog_out_two: 1'b0, analog_out_two_oe_n: 1'b1,
                  bus: 6'h00, pick: 1'b0, tx_act: 1'b0, rx_act: 1'b0,
                  prbs_on: 1'b0, prbs_bit: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign analog_out_one_o = st_reg.analog_out_one;
  assign analog_out_one_oe_n_o = st_reg.analog_out_one_oe_n;
  assign analog_out_two_o = st_reg.analog_out_two;
  assign analog_out_two_oe_n_o = st_reg.analog_out_two_oe_n;
  assign test_bus_o = st_reg.bus;
  assign picked_test_bit_o = st_reg.pick;
  assign transmit_activity_o = st_reg.tx_act;
  assign receive_activity_o = st_reg.rx_act;
  assign prbs_active_o = st_reg.prbs_on;
  assign prbs_data_o = st_reg.prbs_bit;

endmodule

/* tb/tsom_test_mux_sva.sv */
`timescale 1ns/1ps
module tsom_test_mux_sva
  import tsom_pkg::*;
(
  // Clock, reset and inputs
  input wire logic ref_clk_i, srst_i, transmit_cmd_i,
  input wire logic [7:0] analog_test_selector_i,
  input wire logic [4:0] test_bus_group_select_i,
  input wire logic [1:0] data_rate_i, prbs_mode_i,
  input wire logic [2:0] rx_phase_i, tx_phase_i,
  input wire logic rx_data_i, rx_coll_i, rx_valid_i, rx_stop_i,
  input wire logic receiver_reset_line_i,
  // Outputs
  input wire logic analog_out_one_o, analog_out_two_o, prbs_active_o,
  input wire logic transmit_activity_o, receive_activity_o,
  input wire logic picked_test_bit_o,
  input wire logic [5:0] test_bus_o
);
  // Previous cycle was out of reset
  logic run_reg;
  always_ff @(posedge ref_clk_i) run_reg <= !srst_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Rate seen one cycle back
  sequence s_low;
    run_reg && $past(data_rate_i) == RATE_106;
  endsequence
  sequence s_high;
    run_reg && $past(data_rate_i) != RATE_106;
  endsequence
  sequence s_cmd;
    transmit_cmd_i && prbs_mode_i != PRBS_OFF;
  endsequence
  AST_ACT_PINS: assert property (
    run_reg && $past(analog_test_selector_i) == 8'hCD |->
    analog_out_one_o == $past(transmit_activity_o) &&
    analog_out_two_o == $past(receive_activity_o))
    else $error("activity pins wrong");
  AST_RX_LOW: assert property (s_low |-> receive_activity_o ==
    ($past(rx_phase_i) inside {PH_DATA, PH_PARITY, PH_CRC}))
    else $error("rx activity low rate");
  AST_TX_LOW: assert property (s_low |-> transmit_activity_o ==
    ($past(tx_phase_i) inside {PH_START, PH_DATA, PH_PARITY, PH_CRC}))
    else $error("tx activity low rate");
  AST_RX_HIGH: assert property (s_high |-> receive_activity_o ==
    ($past(rx_phase_i) inside {PH_DATA, PH_CRC}))
    else $error("rx activity high rate");
  AST_TX_HIGH: assert property (s_high |-> transmit_activity_o ==
    ($past(tx_phase_i) inside {PH_DATA, PH_CRC}))
    else $error("tx activity high rate");
  AST_BUS: assert property (run_reg |-> test_bus_o ==
    ($past(test_bus_group_select_i) == GROUP_RX ? $past({rx_data_i,
    rx_coll_i, rx_valid_i, rx_stop_i, receiver_reset_line_i, 1'b0}) :
    6'h00)) else $error("test bus wrong");
  AST_PICK_PINS: assert property (
    run_reg && $past(analog_test_selector_i) == 8'hFF |->
    analog_out_one_o == $past(picked_test_bit_o) &&
    analog_out_two_o == $past(picked_test_bit_o))
    else $error("picked bit pins wrong");
  AST_PRBS_GO: assert property (s_cmd |=> prbs_active_o)
    else $error("pattern did not start");
  AST_PRBS_CAUSE: assert property (
    run_reg && $rose(prbs_active_o) |-> $past(transmit_cmd_i))
    else $error("pattern started alone");
endmodule

bind tsom_test_mux tsom_test_mux_sva u_sva (.*);

/* tb/tsom_scope.sv */
`timescale 1ns/1ps
module tsom_scope (
  // Pins under observation
  input wire logic pin_one_i, oe_one_n_i, pin_two_i, oe_two_n_i,
  // Levels seen with the pull-down fitted
  output logic wire_one_o, wire_two_o
);
  // Released pin reads low through the pull-down
  assign wire_one_o = oe_one_n_i ? 1'b0 : pin_one_i;
  assign wire_two_o = oe_two_n_i ? 1'b0 : pin_two_i;
endmodule

/* tb/test_tsom_test_mux.sv */
`timescale 1ns/1ps
module test_tsom_test_mux import tsom_pkg::*;;
  typedef struct packed {
    logic [7:0] s; logic [4:0] g; logic [2:0] p; logic [5:0] d;
    logic [1:0] a, r; logic [2:0] t, x; logic [1:0] e;
  } tsom_row_t;
  logic ref_clk_i = 0, srst_i = 1, cmd = 0, stb = 0, fend = 0, fins = 0;
  logic [7:0] sel = 8'h00;
  logic [4:0] grp = 5'h00;
  logic [2:0] pk = 3'h0, tp = 3'h0, rp = 3'h0;
  logic [1:0] mode = 2'h0, rate = 2'h0, adc = 2'h0;
  logic [5:0] src = 6'h00, bus;
  logic [39:0] bs;
  logic o1, oe1, o2, oe2, act, pdat, pick, txa, rxa, w1, w2;
  int fail_count = 0, comparisons = 0, bad1, bad2, tl, tt;
  // Selector, sources, rate, phases and expected pin levels
  tsom_row_t rows [14] = '{
    '{8'h56,5'h00,3'h0,6'h00,2'h2,2'h0,3'h0,3'h0,2'h2},
    '{8'h56,5'h00,3'h0,6'h00,2'h1,2'h0,3'h0,3'h0,2'h1},
    '{8'hAB,5'h00,3'h0,6'h00,2'h0,2'h0,3'h0,3'h0,2'h2},
    '{8'hBA,5'h00,3'h0,6'h00,2'h0,2'h0,3'h0,3'h0,2'h1},
    '{8'h0A,5'h00,3'h0,6'h3F,2'h3,2'h0,3'h0,3'h0,2'h1},
    '{8'hEE,5'h00,3'h0,6'h01,2'h0,2'h0,3'h0,3'h0,2'h3},
    '{8'hFF,5'h07,3'h6,6'h20,2'h0,2'h0,3'h0,3'h0,2'h3},
    '{8'hFF,5'h07,3'h6,6'h1E,2'h3,2'h0,3'h0,3'h0,2'h0},
    '{8'hFF,5'h07,3'h5,6'h20,2'h0,2'h0,3'h0,3'h0,2'h0},
    '{8'hCD,5'h00,3'h0,6'h00,2'h0,2'h0,3'h1,3'h1,2'h2},
    '{8'hCD,5'h00,3'h0,6'h00,2'h0,2'h0,3'h2,3'h2,2'h3},
    '{8'hCD,5'h00,3'h0,6'h00,2'h0,2'h1,3'h1,3'h3,2'h1},
    '{8'hCD,5'h00,3'h0,6'h00,2'h0,2'h2,3'h2,3'h2,2'h0},
    '{8'hCD,5'h00,3'h0,6'h00,2'h0,2'h3,3'h6,3'h6,2'h3}};
  always #12.5 ref_clk_i = ~ref_clk_i;
  tsom_test_mux DUT (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .analog_test_selector_i(sel), .test_bus_group_select_i(grp),
    .bus_bit_picker_i(pk), .prbs_mode_i(mode), .data_rate_i(rate),
    .rx_phase_i(rp), .tx_phase_i(tp), .transmit_cmd_i(cmd),
    .tx_bit_strobe_i(stb), .tx_frame_end_i(fend), .framing_insert_i(fins),
    .rx_data_i(src[5]), .rx_coll_i(src[4]), .rx_valid_i(src[3]),
    .rx_stop_i(src[2]), .receiver_reset_line_i(src[1]),
    .subcarrier_det_i(src[0]), .adc_i_i(adc[1]), .adc_q_i(adc[0]),
    .dac_reg_one_i(1'b0), .dac_reg_two_i(1'b0), .dac_corr_i(1'b0),
    .dac_minlvl_i(1'b0), .analog_out_one_o(o1),
    .analog_out_one_oe_n_o(oe1), .analog_out_two_o(o2),
    .analog_out_two_oe_n_o(oe2), .test_bus_o(bus), .prbs_active_o(act),
    .prbs_data_o(pdat), .picked_test_bit_o(pick),
    .transmit_activity_o(txa), .receive_activity_o(rxa));
  tsom_scope SCOPE (.pin_one_i(o1), .oe_one_n_i(oe1), .pin_two_i(o2),
    .oe_two_n_i(oe2), .wire_one_o(w1), .wire_two_o(w2));
  // Compare and count
  task chk(input logic [5:0] s, e, input string m);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One bit strobe, optionally during framing insertion
  task strobe(input logic f);
    fins = f;
    stb = 1;
    @(negedge ref_clk_i);
    stb = 0;
    fins = 0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (8) @(negedge ref_clk_i);
    srst_i = 0;
    foreach (rows[i]) begin
      {sel, grp, pk, src, adc, rate, tp, rp} = rows[i][33:2];
      repeat (4) @(negedge ref_clk_i);
      chk({w1, w2}, rows[i].e, "aux level");
      chk(bus, (grp == GROUP_RX) ? {src[5:1], 1'b0} : 6'h00, "bus");
    end
    cmd = 1;
    @(negedge ref_clk_i);
    cmd = 0;
    @(negedge ref_clk_i);
    chk(act, 1'b0, "cmd without mode");
    for (int m = 1; m < 3; m++) begin
      tl = (m == 1) ? 9 : 15;
      tt = (m == 1) ? 5 : 14;
      mode = m[1:0]; // Rate and framing already set
      repeat (3) @(negedge ref_clk_i);
      chk(act, 1'b0, "started on select");
      cmd = 1;
      @(negedge ref_clk_i);
      cmd = 0;
      chk(act, 1'b1, "no start on cmd");
      for (int n = 0; n < 40; n++) begin
        if (n % 7 == 3) strobe(1'b1);
        strobe(1'b0);
        bs[n] = pdat;
      end
      bad1 = 0;
      bad2 = 0;
      for (int n = 15; n < 40; n++) begin
        bad1 += (bs[n] !== (bs[n-tl] ^ bs[n-tt]));
        bad2 += (bs[n] !== (bs[n-tl] ^ bs[n-tl+tt]));
      end
      chk((bad1 != 0 && bad2 != 0) || bs == 40'h0, 1'b0, "pattern");
      fend = 1;
      @(negedge ref_clk_i);
      fend = 0;
      @(negedge ref_clk_i);
      chk(act, 1'b0, "no stop at frame end");
    end
    srst_i = 1;
    @(negedge ref_clk_i);
    chk({oe1, oe2, o1, o2, |bus, act}, 6'h30, "reset state");
    stop_test;
  end
endmodule
